/* src/aepl_cfg.svh */
// Constants of the auxiliary event pin: register map, fields and resets.
// Assumes inclusion by bare name from every design file of the block but the package.
`ifndef AEPL_CFG_SVH
`define AEPL_CFG_SVH

// Byte offsets inside the slave window
`define AEPL_OFS_CTRL      8'h00
`define AEPL_OFS_STATUS    8'h04
`define AEPL_OFS_COUNT     8'h08
`define AEPL_OFS_MSB       7

// Control register fields
`define AEPL_CTRL_DIR_BIT  0
`define AEPL_CTRL_INV_BIT  1
`define AEPL_CTRL_ACT_LSB  4
`define AEPL_CTRL_ACT_MSB  6
`define AEPL_CTRL_SRC_LSB  8
`define AEPL_CTRL_SRC_MSB  10
`define AEPL_CTRL_WMASK    32'h0000_0773
`define AEPL_CTRL_RESET    32'h0000_0000

// Status register fields
`define AEPL_STAT_LVL_BIT  0
`define AEPL_STAT_OUT_BIT  1
`define AEPL_STAT_EDGE_BIT 2
`define AEPL_STAT_DIR_BIT  3
`define AEPL_STAT_ACT_LSB  4
`define AEPL_STAT_ACT_MSB  6

// Bus encodings
`define AEPL_HTRANS_NONSEQ 2'h2
`define AEPL_HSIZE_WORD    3'h2
`define AEPL_HRESP_OKAY    1'h0

// Synchroniser settle cycles after reset before edges count
`define AEPL_SETTLE_CYC    2'h3

`endif

/* src/aepl_pkg.sv */
// Types shared by the auxiliary event pin block.
// Assumes the constants header is compiled alongside.
package aepl_pkg;

  // Action taken on an active input edge
  typedef enum logic [2:0] {
    AEPL_ACT_NONE,
    AEPL_ACT_STOP,
    AEPL_ACT_POWER_OFF,
    AEPL_ACT_MOVE_REL,
    AEPL_ACT_HOME,
    AEPL_ACT_ALARM
  } aepl_act_e;

  // Status condition shown on the pin in output mode
  typedef enum logic [2:0] {
    AEPL_SRC_OFF,
    AEPL_SRC_ON,
    AEPL_SRC_MOVING,
    AEPL_SRC_ALARM,
    AEPL_SRC_WINDINGS,
    AEPL_SRC_MOTOR
  } aepl_src_e;

endpackage

/* src/aepl_edge_sync.sv */
// Two-stage synchroniser and active-edge detector for the pin input.
// Assumes the pin is asynchronous to i_sys_clk.
`timescale 1ns/1ps
`include "aepl_cfg.svh"

module aepl_edge_sync (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_sys_rst,
  // Pin and polarity
  input  wire logic i_pin,
  input  wire logic i_invert,
  // Results
  output logic      o_level,
  output logic      o_active_edge
);
  import aepl_pkg::*;

  logic       meta_r;
  logic       sync_r;
  logic       prev_r;
  logic       edge_r;
  logic [1:0] settle_r;
  logic       active;

  // Two flops before any logic looks at the pin
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Hold off edges until the chain holds real pin samples
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      settle_r <= 2'h0;
    end else if (settle_r != `AEPL_SETTLE_CYC) begin
      settle_r <= settle_r + 2'h1;
    end
  end

  // Polarity picks rising or falling; one pulse per transition
  assign active = (settle_r == `AEPL_SETTLE_CYC) &&
                  (i_invert ? (prev_r & ~sync_r)
                            : (~prev_r & sync_r));

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      edge_r <= 1'b0;
    end else begin
      edge_r <= active;
    end
  end

  assign o_level       = sync_r;
  assign o_active_edge = edge_r;
endmodule

/* src/aepl_out_mux.sv */
// Selects the controller status condition shown on the pin.
// Assumes all status inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "aepl_cfg.svh"

module aepl_out_mux (
  // Selection
  input  aepl_pkg::aepl_src_e i_src,
  // Controller status
  input  wire logic           i_moving,
  input  wire logic           i_alarm,
  input  wire logic           i_windings_on,
  input  wire logic           i_motor_found,
  // Chosen level
  output logic                o_level
);
  import aepl_pkg::*;

  // Unused codes fall back to inactive
  always_comb begin
    o_level = 1'b0;
    case (i_src)
      AEPL_SRC_OFF:      o_level = 1'b0;
      AEPL_SRC_ON:       o_level = 1'b1;
      AEPL_SRC_MOVING:   o_level = i_moving;
      AEPL_SRC_ALARM:    o_level = i_alarm;
      AEPL_SRC_WINDINGS: o_level = i_windings_on;
      AEPL_SRC_MOTOR:    o_level = i_motor_found;
      default:           o_level = 1'b0;
    endcase
  end
endmodule

/* src/aepl_top.sv */
// Auxiliary event pin: AHB-Lite register slave, input action dispatch
// and status-driven output.
// Assumes one AHB-Lite master, zero-wait answers, and controller status
// and command signals on i_sys_clk.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "aepl_cfg.svh"

module aepl_top #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Auxiliary event pin, three-signal form
  input  wire logic        i_aux_event_pin,
  output logic             o_aux_event_pin,
  output logic             o_aux_event_pin_oe_n,
  // Controller status
  input  wire logic        i_moving,
  input  wire logic        i_alarm,
  input  wire logic        i_windings_on,
  input  wire logic        i_motor_found,
  // Controller commands, one-cycle pulses
  output logic             o_stop_cmd,
  output logic             o_power_off_cmd,
  output logic             o_move_rel_cmd,
  output logic             o_home_cmd,
  output logic             o_alarm_cmd
);
  import aepl_pkg::*;

  // Register map, one aligned word at each selector:
  //   control - direction, input polarity, input action, output source
  //   status  - synced level, drive value, sticky edge flag (write one
  //             to clear), direction, last action dispatched
  //   count   - active edges taken in input mode; any write clears it
  // Unmapped offsets read zero and drop writes; every answer is OKAY.

  // Register selector codes
  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_CTRL   = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_COUNT  = 2'h3;

  // Bus state
  logic             wr_pend_r;
  logic [1:0]       wr_sel_r;
  logic [31:0]      hrdata_r;
  logic             hreadyout_r;
  logic             hresp_r;
  logic             addr_take;
  logic [1:0]       addr_sel;

  // Register state
  logic [31:0]      ctrl_r;
  logic [31:0]      ctrl_nxt;
  logic             edge_seen_r;
  logic             edge_seen_nxt;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  aepl_act_e        last_act_r;

  // Pin and command state
  logic             pin_out_r;
  logic             pin_oe_n_r;
  logic             stop_r;
  logic             power_off_r;
  logic             move_rel_r;
  logic             home_r;
  logic             alarm_r;

  // Decoded control fields
  logic             dir_out;
  logic             invert;
  aepl_act_e        act_sel;
  aepl_src_e        src_sel;

  // Sub-block results
  logic             in_level;
  logic             in_edge;
  logic             src_level;
  logic             fire;

  // Read path words
  logic [31:0]      status_word;
  logic [31:0]      count_word;
  logic [31:0]      rd_word;

  // Maps a byte offset to a register selector. Only the low address
  // bits are decoded, so the window repeats through the slave's space.
  function automatic logic [1:0] reg_decode(
    input logic [`AEPL_OFS_MSB:0] ofs
  );
    logic [1:0] sel;
    sel = SEL_NONE;
    if (ofs == `AEPL_OFS_CTRL) begin
      sel = SEL_CTRL;
    end else if (ofs == `AEPL_OFS_STATUS) begin
      sel = SEL_STATUS;
    end else if (ofs == `AEPL_OFS_COUNT) begin
      sel = SEL_COUNT;
    end
    return sel;
  endfunction

  // Field extraction from the stored control word. Spare action and
  // source codes are kept as written and treated as none and off.
  assign dir_out = ctrl_r[`AEPL_CTRL_DIR_BIT];
  assign invert  = ctrl_r[`AEPL_CTRL_INV_BIT];
  assign act_sel = aepl_act_e'(ctrl_r[`AEPL_CTRL_ACT_MSB:`AEPL_CTRL_ACT_LSB]);
  assign src_sel = aepl_src_e'(ctrl_r[`AEPL_CTRL_SRC_MSB:`AEPL_CTRL_SRC_LSB]);

  // Pin input path. The pin is asynchronous, so it passes two flops
  // before anything looks at it; edges are held off for a few cycles
  // after reset while the chain fills with real samples.
  aepl_edge_sync u_edge_sync (
    .i_sys_clk     (i_sys_clk),
    .i_sys_rst     (i_sys_rst),
    .i_pin         (i_aux_event_pin),
    .i_invert      (invert),
    .o_level       (in_level),
    .o_active_edge (in_edge)
  );

  // Status source selection for output mode; the status inputs come
  // from logic on this clock and need no synchroniser.
  aepl_out_mux u_out_mux (
    .i_src         (src_sel),
    .i_moving      (i_moving),
    .i_alarm       (i_alarm),
    .i_windings_on (i_windings_on),
    .i_motor_found (i_motor_found),
    .o_level       (src_level)
  );

  // An edge only counts while the pin is an input. The synchroniser
  // keeps sampling in output mode, so edges made by our own drive
  // still reach in_edge; they are dropped here unless dir_out has
  // cleared by the time they arrive, three cycles after the pin moved.
  assign fire = in_edge & ~dir_out;

  // Address phase accepted on a selected NONSEQ with the bus ready;
  // IDLE and BUSY transfers are ignored and answered OKAY
  assign addr_take = i_hsel && i_hready &&
                     (i_htrans == `AEPL_HTRANS_NONSEQ);
  assign addr_sel  = reg_decode(i_haddr[`AEPL_OFS_MSB:0]);

  // Write phase bookkeeping; only whole-word writes are kept. The
  // address phase is remembered here because the write data only
  // arrive one cycle later, in the data phase.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_sel_r  <= SEL_NONE;
    end else begin
      wr_pend_r <= addr_take && i_hwrite &&
                   (i_hsize == `AEPL_HSIZE_WORD);
      wr_sel_r  <= addr_sel;
    end
  end

  // Control word next value, reserved bits held at zero
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_pend_r && (wr_sel_r == SEL_CTRL)) begin
      ctrl_nxt = i_hwdata & `AEPL_CTRL_WMASK;
    end
  end

  // Sticky edge flag: write one to clear. A new edge in the clearing
  // cycle wins, so software never loses an event it has not seen.
  always_comb begin
    edge_seen_nxt = edge_seen_r;
    if (wr_pend_r && (wr_sel_r == SEL_STATUS) &&
        i_hwdata[`AEPL_STAT_EDGE_BIT]) begin
      edge_seen_nxt = 1'b0;
    end
    if (fire) begin
      edge_seen_nxt = 1'b1;
    end
  end

  // Event counter: any write clears, a same-cycle event still counts.
  // It wraps silently; software reads it often enough to tell.
  always_comb begin
    count_nxt = count_r;
    if (wr_pend_r && (wr_sel_r == SEL_COUNT)) begin
      count_nxt = '0;
    end
    if (fire) begin
      count_nxt = count_nxt + CNT_W'(1);
    end
  end

  // Control register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctrl_r <= `AEPL_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Status flag and counter
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      edge_seen_r <= 1'b0;
      count_r     <= '0;
    end else begin
      edge_seen_r <= edge_seen_nxt;
      count_r     <= count_nxt;
    end
  end

  // Last action dispatched, for software to read back; it also records
  // the none action, so software can tell that an edge was taken
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      last_act_r <= AEPL_ACT_NONE;
    end else if (fire) begin
      last_act_r <= act_sel;
    end
  end

  // Status word as software reads it; unlisted bits stay zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`AEPL_STAT_LVL_BIT]  = in_level;
    status_word[`AEPL_STAT_OUT_BIT]  = pin_out_r;
    status_word[`AEPL_STAT_EDGE_BIT] = edge_seen_nxt;
    status_word[`AEPL_STAT_DIR_BIT]  = dir_out;
    status_word[`AEPL_STAT_ACT_MSB:`AEPL_STAT_ACT_LSB] = last_act_r;
  end

  // Counter word, zero-extended to the bus width; the counter must
  // not be made wider than one bus word
  always_comb begin
    count_word = 32'h0000_0000;
    count_word[CNT_W-1:0] = count_nxt;
  end

  // Read mux over next values of control, flag and counter, so a read right behind a write or an
  // edge sees its effect there; status direction and last action lag a cycle
  always_comb begin
    rd_word = 32'h0000_0000;
    if (addr_sel == SEL_CTRL) begin
      rd_word = ctrl_nxt;
    end else if (addr_sel == SEL_STATUS) begin
      rd_word = status_word;
    end else if (addr_sel == SEL_COUNT) begin
      rd_word = count_word;
    end
  end

  // Read data captured at the address phase; it stands through the
  // data phase and until the next read is taken
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_take && !i_hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  // Zero-wait slave, always OKAY. Both are kept in flops so that every
  // output of the block leaves straight from a register.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= `AEPL_HRESP_OKAY;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r     <= `AEPL_HRESP_OKAY;
    end
  end

  // Pin drive: enable low only in output mode. The drive value is held
  // low while the pin is an input, so a later switch to output never
  // shows a stale level; invert does not touch the output polarity.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pin_oe_n_r <= 1'b1;
      pin_out_r  <= 1'b0;
    end else begin
      pin_oe_n_r <= ~dir_out;
      pin_out_r  <= dir_out ? src_level : 1'b0;
    end
  end

  // Command pulses, one cycle per active edge. Only one action is
  // selected at a time, so at most one pulse leaves per edge; the
  // none action and the spare codes still count but issue nothing.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      stop_r      <= 1'b0;
      power_off_r <= 1'b0;
      move_rel_r  <= 1'b0;
      home_r      <= 1'b0;
      alarm_r     <= 1'b0;
    end else begin
      stop_r      <= 1'b0;
      power_off_r <= 1'b0;
      move_rel_r  <= 1'b0;
      home_r      <= 1'b0;
      alarm_r     <= 1'b0;
      if (fire) begin
        case (act_sel)
          AEPL_ACT_STOP:      stop_r      <= 1'b1;
          AEPL_ACT_POWER_OFF: power_off_r <= 1'b1;
          AEPL_ACT_MOVE_REL:  move_rel_r  <= 1'b1;
          AEPL_ACT_HOME:      home_r      <= 1'b1;
          AEPL_ACT_ALARM:     alarm_r     <= 1'b1;
          default:            stop_r      <= 1'b0;
        endcase
      end
    end
  end

  // Outputs straight from flops; no logic sits between a register and
  // its pin
  assign o_hreadyout          = hreadyout_r;
  assign o_hresp              = hresp_r;
  assign o_hrdata             = hrdata_r;
  assign o_aux_event_pin      = pin_out_r;
  assign o_aux_event_pin_oe_n = pin_oe_n_r;
  assign o_stop_cmd           = stop_r;
  assign o_power_off_cmd      = power_off_r;
  assign o_move_rel_cmd       = move_rel_r;
  assign o_home_cmd           = home_r;
  assign o_alarm_cmd          = alarm_r;
endmodule

/* tb/aepl_props.sv */
// Port checker of the auxiliary event pin block.
// Assumes binding to aepl_top; one clock, synchronous reset.
`timescale 1ns/1ps

module aepl_props (
  // Clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_sys_rst,
  // Bus
  input wire logic       i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic       i_hwrite,
  input wire logic       i_hready,
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  // Pin
  input wire logic       i_aux_event_pin,
  input wire logic       o_aux_event_pin,
  input wire logic       o_aux_event_pin_oe_n,
  // Commands
  input wire logic       o_stop_cmd,
  input wire logic       o_power_off_cmd,
  input wire logic       o_move_rel_cmd,
  input wire logic       o_home_cmd,
  input wire logic       o_alarm_cmd
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // Any command pulse and recent pin history
  logic       cmd;
  logic [6:0] hist_r;
  assign cmd = o_stop_cmd | o_power_off_cmd | o_move_rel_cmd |
               o_home_cmd | o_alarm_cmd;
  always_ff @(posedge i_sys_clk) begin
    hist_r <= {hist_r[5:0], i_aux_event_pin};
  end

  // Read request taken, and a pin that moved in the pipeline span
  sequence s_rd;
    i_hsel && i_hready && i_htrans == 2'h2 && !i_hwrite;
  endsequence
  sequence s_pin_moved;
    hist_r[6:1] != 6'h00 && hist_r[6:1] != 6'h3F;
  endsequence

  a_ready_high: assert property (o_hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!o_hresp)
    else $error("hresp not okay");
  a_rd_answer: assert property (s_rd |=> o_hreadyout && !o_hresp)
    else $error("read answered badly");
  a_cmd_onehot: assert property (
    $onehot0({o_stop_cmd, o_power_off_cmd, o_move_rel_cmd, o_home_cmd,
              o_alarm_cmd})) else $error("two commands at once");
  a_cmd_pulse: assert property (cmd |=> !cmd)
    else $error("command longer than one cycle");
  a_cmd_input: assert property (cmd |-> o_aux_event_pin_oe_n)
    else $error("command in output mode");
  a_cmd_cause: assert property (cmd |-> s_pin_moved)
    else $error("command without pin edge");
  a_input_quiet: assert property (
    o_aux_event_pin_oe_n |-> !o_aux_event_pin)
    else $error("pin value driven in input mode");
endmodule

bind aepl_top aepl_props u_props (.i_sys_clk, .i_sys_rst, .i_hsel,
  .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hresp,
  .i_aux_event_pin, .o_aux_event_pin, .o_aux_event_pin_oe_n,
  .o_stop_cmd, .o_power_off_cmd, .o_move_rel_cmd, .o_home_cmd,
  .o_alarm_cmd);

/* tb/aepl_ext_equip.sv */
// Model of the equipment wired to the auxiliary pin.
// Assumes the design's output enable is active low.
`timescale 1ns/1ps

module aepl_ext_equip (
  // Level the equipment puts on the pin
  input  wire logic i_drive,
  // Design side of the pin
  input  wire logic i_pin_out,
  input  wire logic i_pin_oe_n,
  // Resolved wire level
  output logic      o_wire
);
  // Equipment drives only while the design has released the pin
  assign o_wire = i_pin_oe_n ? i_drive : i_pin_out;
endmodule

/* tb/tb_aux_event_pin_logic.sv */
// Testbench of the auxiliary event pin block.
// Assumes the checker is bound and the pin model resolves the wire.
`timescale 1ns/1ps

module tb_aux_event_pin_logic;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        drive = 1'b0;
  logic [3:0]  st = 4'h0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pin_wire;
  logic        pin_out;
  logic        oe_n;
  logic [4:0]  cmd;
  int          n_cmd [5];
  int          n_fail = 0;
  int          comparisons = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  aepl_top i_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_aux_event_pin(pin_wire), .o_aux_event_pin(pin_out),
    .o_aux_event_pin_oe_n(oe_n), .i_moving(st[0]), .i_alarm(st[1]),
    .i_windings_on(st[2]), .i_motor_found(st[3]),
    .o_stop_cmd(cmd[0]), .o_power_off_cmd(cmd[1]),
    .o_move_rel_cmd(cmd[2]), .o_home_cmd(cmd[3]), .o_alarm_cmd(cmd[4]));

  aepl_ext_equip i_equip (.i_drive(drive), .i_pin_out(pin_out),
    .i_pin_oe_n(oe_n), .o_wire(pin_wire));

  // Command pulse tally, away from the launching edge
  always @(negedge clk) begin
    for (int k = 0; k < 5; k++) begin
      n_cmd[k] += int'(cmd[k]);
    end
  end

  // One single-word AHB-Lite transfer
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // Input mode after reset, registers clear, spare offset reads zero
  task automatic t_after_reset();
    logic [31:0] r;
    chk("oe_n", 32'h1, {31'h0, oe_n});
    chk("pin_out", 32'h0, {31'h0, pin_out});
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, r);
      chk("reg", 32'h0, r);
    end
  endtask

  // Every action under both polarities, one pulse per active edge
  task automatic t_inputs();
    logic [31:0] r;
    for (int inv = 0; inv < 2; inv++) begin
      for (int a = 0; a < 6; a++) begin
        drive <= 1'(inv);
        repeat (6) @(posedge clk);
        bus(1'b1, 8'h00, 32'((a << 4) | (inv << 1)), r);
        bus(1'b1, 8'h08, 32'h0, r);
        n_cmd = '{default: 0};
        @(posedge clk);
        drive <= 1'(inv == 0);
        repeat (8) @(posedge clk);
        drive <= 1'(inv);
        repeat (8) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
          chk("cmd", 32'(k == a - 1), 32'(n_cmd[k]));
        end
        bus(1'b0, 8'h08, 32'h0, r);
        chk("count", 32'h1, r);
        bus(1'b0, 8'h04, 32'h0, r);
        chk("status", 32'((a << 4) | 4 | inv), r);
        bus(1'b1, 8'h04, 32'h4, r);
        bus(1'b0, 8'h04, 32'h0, r);
        chk("flag clr", 32'((a << 4) | inv), r);
      end
    end
  endtask

  // Every output source against each status input alone
  task automatic t_outputs();
    logic [31:0] r;
    logic        e;
    for (int s = 0; s < 6; s++) begin
      bus(1'b1, 8'h00, 32'((s << 8) | 32'h11), r);
      n_cmd = '{default: 0};
      for (int b = 0; b < 4; b++) begin
        @(posedge clk);
        st <= 4'(1 << b);
        repeat (3) @(negedge clk);
        e = (s == 1) || (s == b + 2);
        chk("oe_n", 32'h0, {31'h0, oe_n});
        chk("pin", 32'(e), {31'h0, pin_out});
      end
      chk("no cmd", 32'h0, 32'(n_cmd[0]));
    end
    bus(1'b1, 8'h00, 32'h0, r);
    repeat (3) @(negedge clk);
    chk("oe_n", 32'h1, {31'h0, oe_n});
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    t_after_reset();
    t_inputs();
    t_outputs();
    report_and_stop();
  end
endmodule
